/* inc/seq_pkg.sv */
// constants, types and reset image shared by the bus cycle sequencer
package seq_pkg;

	localparam int ADDR_W = 16; // external address bus width
	localparam int DATA_W = 8; // external data bus width
	localparam int REFRESH_W = 7; // refresh address bits on the low address lines
	localparam int MCLK_PERIOD_NS = 100; // one mclk cycle is one half of a T-state
	localparam int IO_AUTO_WAITS = 1; // automatic wait states in I/O cycles
	localparam int INTACK_AUTO_WAITS = 2; // automatic wait states in interrupt acknowledge
	localparam logic [1:0] IO_AUTO_LOAD = 2'(IO_AUTO_WAITS - 1);
	localparam logic [1:0] INTACK_AUTO_LOAD = 2'(INTACK_AUTO_WAITS - 1);
	localparam logic [REFRESH_W-1:0] REFRESH_RESET = 7'h00;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

	// T-states, gray coded along idle, T1, T2, TW, T3, T4
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_T1 = 3'h1,
		ST_T2 = 3'h3,
		ST_TW = 3'h2,
		ST_T3 = 3'h6,
		ST_T4 = 3'h7,
		ST_HELD = 3'h5
	} tstate_t;

	// machine cycle kinds requested by the core
	typedef enum logic [2:0] {
		K_FETCH = 3'h0,
		K_MEM_RD = 3'h1,
		K_MEM_WR = 3'h2,
		K_IO_RD = 3'h3,
		K_IO_WR = 3'h4,
		K_INTACK = 3'h5
	} kind_t;

	typedef struct packed {
		tstate_t st;
		kind_t kind;
		logic [1:0] auto_left;
		logic wait_seen;
		logic int_pend;
		logic rst_seen;
		logic done;
		logic [REFRESH_W-1:0] refresh_strobe_n_cnt;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] addr_pin;
		logic [DATA_W-1:0] dout;
		logic [DATA_W-1:0] rdata;
		logic addr_oe_n;
		logic data_oe_n;
		logic ctrl_oe_n;
		logic memory_request_n_n;
		logic io_request_n_n;
		logic rd_n;
		logic wr_n;
		logic m1_n;
		logic refresh_strobe_n_n;
		logic grant_n;
	} seq_state_t;

	localparam seq_state_t SEQ_RESET = '{
		st: ST_IDLE, kind: K_FETCH, auto_left: 2'h0, wait_seen: 1'b0,
		int_pend: 1'b0, rst_seen: 1'b0, done: 1'b0, refresh_strobe_n_cnt: REFRESH_RESET,
		addr: ADDR_RESET, addr_pin: ADDR_RESET, dout: DATA_RESET, rdata: DATA_RESET,
		addr_oe_n: 1'b1, data_oe_n: 1'b1, ctrl_oe_n: 1'b0, memory_request_n_n: 1'b1,
		io_request_n_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, m1_n: 1'b1, refresh_strobe_n_n: 1'b1,
		grant_n: 1'b1
	};

endpackage

/* core/half_phase.sv */
// half T-state phase generator: low while in the high clock half, high in the low half
module half_phase (
	input wire logic mclk, // system clock
	input wire logic srst, // synchronous reset, active high
	input wire logic ce, // clock enable
	output logic phase // 0: after rising edge, 1: after falling edge
);

	typedef struct packed {
		logic ph;
	} phase_state_t;

	phase_state_t s_reg;
	phase_state_t s_next;

	// toggle once per enabled cycle
	always_comb begin
		s_next = s_reg;
		s_next.ph = ~s_reg.ph;
	end

	// register the phase
	always_ff @(posedge mclk) begin
		if (srst) begin
			s_reg <= '{ph: 1'b1};
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign phase = s_reg.ph;

endmodule

/* core/bus_cycle_sequencer.sv */
// bus cycle sequencer: fetch, memory, I/O and interrupt acknowledge cycles
module bus_cycle_sequencer (
	input wire logic mclk, // system clock, two cycles per T-state
	input wire logic srst, // synchronous reset, active high
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic cmd_valid, // core requests a machine cycle
	output logic cmd_ready, // request taken this cycle
	input wire seq_pkg::kind_t cmd_kind, // kind of machine cycle
	input wire logic [15:0] cmd_addr, // address or program counter
	input wire logic [7:0] cmd_wdata, // write data
	input wire logic instr_last, // current cycle ends the instruction
	output logic done, // one-cycle pulse at cycle end
	output logic [7:0] rdata, // captured read data or vector
	output logic int_pending, // interrupt seen at instruction end
	output logic cpu_reset, // reset pin seen low
	output logic [15:0] addr_out, // address bus
	output logic addr_oe_n, // address bus enable, low drives
	input wire logic [7:0] data_in, // data bus input
	output logic [7:0] data_out, // data bus output
	output logic data_oe_n, // data bus enable, low drives
	output logic memory_request_n, // memory request strobe
	output logic io_request_n, // I/O request strobe
	output logic read_strobe_n, // read strobe
	output logic write_strobe_n, // write strobe
	output logic ctrl_oe_n, // three-state control enable, low drives
	output logic fetch_cycle_n, // fetch-type cycle indicator
	output logic refresh_strobe_n, // refresh strobe
	output logic bus_grant_n, // bus granted to another master
	input wire logic wait_n, // wait request
	input wire logic int_n, // maskable interrupt request
	input wire logic bus_request_n, // bus request
	input wire logic reset_n // reset pin
);

	seq_pkg::seq_state_t s_reg;
	seq_pkg::seq_state_t s_next;
	logic ph;
	logic m1_cur;
	logic at_end;
	logic accept;
	logic nph;
	logic busy;
	logic early;
	logic io_win;
	logic nm1;
	logic nmem;
	logic t3;
	logic t4;
	logic tw;

	half_phase u_phase (
		.mclk(mclk),
		.srst(srst),
		.ce(ce),
		.phase(ph)
	);

	// cycle decode of the current state
	assign m1_cur = s_reg.kind == seq_pkg::K_FETCH || s_reg.kind == seq_pkg::K_INTACK;
	assign at_end = m1_cur ? s_reg.st == seq_pkg::ST_T4 : s_reg.st == seq_pkg::ST_T3;
	assign accept = ph && !s_reg.rst_seen && reset_n && bus_request_n
		&& (s_reg.st == seq_pkg::ST_IDLE || at_end);
	assign cmd_ready = ce && accept;

	// next state and registered pin values
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		if (!ph) begin
			s_next.wait_seen = !wait_n;
			if (s_reg.st == seq_pkg::ST_T3
				&& (s_reg.kind == seq_pkg::K_MEM_RD || s_reg.kind == seq_pkg::K_IO_RD)) begin
				s_next.rdata = data_in;
			end
		end else begin
			s_next.rst_seen = !reset_n;
			case (s_reg.st)
				seq_pkg::ST_IDLE: begin
					s_next.st = !bus_request_n ? seq_pkg::ST_HELD : seq_pkg::ST_IDLE;
				end
				seq_pkg::ST_T1: begin
					s_next.st = seq_pkg::ST_T2;
				end
				seq_pkg::ST_T2: begin
					if (s_reg.kind == seq_pkg::K_IO_RD || s_reg.kind == seq_pkg::K_IO_WR) begin
						s_next.st = seq_pkg::ST_TW;
						s_next.auto_left = seq_pkg::IO_AUTO_LOAD;
					end else if (s_reg.kind == seq_pkg::K_INTACK) begin
						s_next.st = seq_pkg::ST_TW;
						s_next.auto_left = seq_pkg::INTACK_AUTO_LOAD;
					end else begin
						s_next.st = s_reg.wait_seen ? seq_pkg::ST_TW : seq_pkg::ST_T3;
						s_next.auto_left = 2'h0;
					end
				end
				seq_pkg::ST_TW: begin
					if (s_reg.auto_left != 2'h0) begin
						s_next.auto_left = s_reg.auto_left - 2'h1;
					end else begin
						s_next.st = s_reg.wait_seen ? seq_pkg::ST_TW : seq_pkg::ST_T3;
					end
				end
				seq_pkg::ST_T3: begin
					s_next.st = m1_cur ? seq_pkg::ST_T4 : seq_pkg::ST_IDLE;
				end
				seq_pkg::ST_T4: begin
					s_next.st = seq_pkg::ST_IDLE;
				end
				seq_pkg::ST_HELD: begin
					s_next.st = bus_request_n ? seq_pkg::ST_IDLE : seq_pkg::ST_HELD;
				end
				default: begin
					s_next.st = seq_pkg::ST_IDLE;
				end
			endcase
			// fetch-type cycles take data at the rising edge opening T3
			if (m1_cur && s_next.st == seq_pkg::ST_T3 && s_reg.st != seq_pkg::ST_T3) begin
				s_next.rdata = data_in;
			end
			// cycle end: report, advance refresh address after fetch-type cycles, honour bus request
			if (at_end) begin
				s_next.done = 1'b1;
				s_next.st = !bus_request_n ? seq_pkg::ST_HELD : seq_pkg::ST_IDLE;
				if (m1_cur) begin
					s_next.refresh_strobe_n_cnt = s_reg.refresh_strobe_n_cnt + 7'h01;
				end
			end
			if (!reset_n) begin
				s_next.st = seq_pkg::ST_IDLE;
				s_next.done = 1'b0;
			end
			if (accept && cmd_valid) begin
				s_next.st = seq_pkg::ST_T1;
				s_next.kind = cmd_kind;
				s_next.addr = cmd_addr;
				s_next.dout = cmd_wdata;
				if (cmd_kind == seq_pkg::K_INTACK) begin
					s_next.int_pend = 1'b0;
				end
			end
			// interrupt taken at the rising edge of the instruction's last T-state
			if (instr_last && reset_n && (s_next.st == seq_pkg::ST_T4
				|| (s_next.st == seq_pkg::ST_T3 && !m1_cur))) begin
				s_next.int_pend = !int_n;
			end
		end

		// pin values for the half T-state that follows
		nph = ~ph;
		busy = s_next.st != seq_pkg::ST_IDLE && s_next.st != seq_pkg::ST_HELD && !s_next.rst_seen;
		tw = s_next.st == seq_pkg::ST_TW;
		t3 = s_next.st == seq_pkg::ST_T3;
		t4 = s_next.st == seq_pkg::ST_T4;
		early = (s_next.st == seq_pkg::ST_T1 && nph) || s_next.st == seq_pkg::ST_T2 || tw;
		io_win = s_next.st == seq_pkg::ST_T2 || tw || (t3 && !nph);
		nm1 = s_next.kind == seq_pkg::K_FETCH || s_next.kind == seq_pkg::K_INTACK;
		nmem = s_next.kind == seq_pkg::K_FETCH || s_next.kind == seq_pkg::K_MEM_RD
			|| s_next.kind == seq_pkg::K_MEM_WR;
		// memory request: access window, then the refresh read
		s_next.memory_request_n_n = !(busy && ((nmem && early) || (nmem && !nm1 && t3 && !nph)
			|| (nm1 && ((t3 && nph) || (t4 && !nph)))));
		s_next.rd_n = !(busy && (((s_next.kind == seq_pkg::K_FETCH
			|| s_next.kind == seq_pkg::K_MEM_RD) && early)
			|| (s_next.kind == seq_pkg::K_MEM_RD && t3 && !nph)
			|| (s_next.kind == seq_pkg::K_IO_RD && io_win)));
		s_next.wr_n = !(busy && ((s_next.kind == seq_pkg::K_MEM_WR
			&& ((s_next.st == seq_pkg::ST_T2 && nph) || tw || (t3 && !nph)))
			|| (s_next.kind == seq_pkg::K_IO_WR && io_win)));
		s_next.io_request_n_n = !(busy && (((s_next.kind == seq_pkg::K_IO_RD
			|| s_next.kind == seq_pkg::K_IO_WR) && io_win)
			|| (s_next.kind == seq_pkg::K_INTACK && tw
			&& (nph || s_next.auto_left == 2'h0))));
		s_next.m1_n = !(busy && nm1 && (s_next.st == seq_pkg::ST_T1
			|| s_next.st == seq_pkg::ST_T2 || tw));
		s_next.refresh_strobe_n_n = !(busy && nm1 && (t3 || t4));
		s_next.addr_pin = (busy && nm1 && (t3 || t4))
			? {{(seq_pkg::ADDR_W - seq_pkg::REFRESH_W){1'b0}}, s_next.refresh_strobe_n_cnt}
			: s_next.addr;
		s_next.data_oe_n = !(busy && (s_next.kind == seq_pkg::K_MEM_WR
			|| s_next.kind == seq_pkg::K_IO_WR)
			&& ((s_next.st == seq_pkg::ST_T1 && nph) || s_next.st == seq_pkg::ST_T2
			|| tw || t3));
		s_next.addr_oe_n = s_next.rst_seen || s_next.st == seq_pkg::ST_HELD;
		s_next.ctrl_oe_n = s_next.st == seq_pkg::ST_HELD;
		s_next.grant_n = !(s_reg.st == seq_pkg::ST_HELD && s_next.st == seq_pkg::ST_HELD);
	end

	// state register
	always_ff @(posedge mclk) begin
		if (srst) begin
			s_reg <= seq_pkg::SEQ_RESET;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// pins and core outputs straight from the register
	assign done = s_reg.done;
	assign rdata = s_reg.rdata;
	assign int_pending = s_reg.int_pend;
	assign cpu_reset = s_reg.rst_seen;
	assign addr_out = s_reg.addr_pin;
	assign addr_oe_n = s_reg.addr_oe_n;
	assign data_out = s_reg.dout;
	assign data_oe_n = s_reg.data_oe_n;
	assign memory_request_n = s_reg.memory_request_n_n;
	assign io_request_n = s_reg.io_request_n_n;
	assign read_strobe_n = s_reg.rd_n;
	assign write_strobe_n = s_reg.wr_n;
	assign ctrl_oe_n = s_reg.ctrl_oe_n;
	assign fetch_cycle_n = s_reg.m1_n;
	assign refresh_strobe_n = s_reg.refresh_strobe_n_n;
	assign bus_grant_n = s_reg.grant_n;

	// address already on the bus when memory request falls in T1
	memory_request_n_half_a: assert property (@(posedge mclk) disable iff (srst)
		($fell(memory_request_n) && s_reg.st == seq_pkg::ST_T1)
		|-> $stable(addr_out) && ph)
		else $error("memory request fell without a stable address half T-state");

	fetch_start_a: assert property (@(posedge mclk) disable iff (srst)
		(cmd_ready && cmd_valid && cmd_kind == seq_pkg::K_FETCH)
		|=> (addr_out == $past(cmd_addr) && !fetch_cycle_n && memory_request_n))
		else $error("fetch did not start with program counter and high request");

	refresh_slot_a: assert property (@(posedge mclk) disable iff (srst)
		!refresh_strobe_n |-> ((s_reg.st == seq_pkg::ST_T3 || s_reg.st == seq_pkg::ST_T4)
		&& addr_out[15:7] == 9'h000 && fetch_cycle_n && read_strobe_n))
		else $error("refresh strobe outside T3 or T4 or with a wide address");

	fetch_capture_a: assert property (@(posedge mclk) disable iff (srst)
		(ce && ph && m1_cur && s_next.st == seq_pkg::ST_T3 && s_reg.st != seq_pkg::ST_T3)
		|=> rdata == $past(data_in))
		else $error("fetch data not taken at the rising edge into T3");

	write_data_a: assert property (@(posedge mclk) disable iff (srst)
		!write_strobe_n |-> (!data_oe_n && $stable(data_out) && !$past(data_oe_n)))
		else $error("write strobe low without stable driven data");

	write_memory_request_n_a: assert property (@(posedge mclk) disable iff (srst)
		(!write_strobe_n && s_reg.kind == seq_pkg::K_MEM_WR)
		|-> (!memory_request_n && $stable(addr_out)))
		else $error("memory write strobe without request on a stable address");

	io_autowait_a: assert property (@(posedge mclk) disable iff (srst)
		(ce && ph && reset_n && s_reg.st == seq_pkg::ST_T2
		&& (s_reg.kind == seq_pkg::K_IO_RD || s_reg.kind == seq_pkg::K_IO_WR))
		|=> s_reg.st == seq_pkg::ST_TW)
		else $error("I/O cycle skipped its automatic wait state");

	wait_hold_a: assert property (@(posedge mclk) disable iff (srst)
		(ce && ph && reset_n && s_reg.st == seq_pkg::ST_TW && s_reg.auto_left == 2'h0
		&& s_reg.wait_seen) |=> s_reg.st == seq_pkg::ST_TW && !done)
		else $error("transfer completed while wait was held");

	intack_lead_a: assert property (@(posedge mclk) disable iff (srst)
		($fell(io_request_n) && s_reg.kind == seq_pkg::K_INTACK)
		|-> (!$past(fetch_cycle_n, 5) && s_reg.st == seq_pkg::ST_TW))
		else $error("acknowledge request came too soon after the fetch indicator");

	edge_only_a: assert property (@(posedge mclk) disable iff (srst)
		($changed(fetch_cycle_n) || $changed(refresh_strobe_n)) |-> !ph)
		else $error("fetch indicator or refresh strobe moved at a falling edge");

	bus_float_a: assert property (@(posedge mclk) disable iff (srst)
		!bus_grant_n |-> (addr_oe_n && data_oe_n && ctrl_oe_n && $past(ctrl_oe_n)))
		else $error("bus granted before outputs floated");

	m1_only_a: assert property (@(posedge mclk) disable iff (srst)
		!fetch_cycle_n |-> (s_reg.kind == seq_pkg::K_FETCH || s_reg.kind == seq_pkg::K_INTACK))
		else $error("fetch indicator low outside a fetch-type cycle");

	io_strobe_a: assert property (@(posedge mclk) disable iff (srst)
		(!io_request_n && s_reg.kind != seq_pkg::K_INTACK)
		|-> ((!read_strobe_n || !write_strobe_n) && memory_request_n))
		else $error("I/O request without read or write");

	reset_idle_a: assert property (@(posedge mclk) disable iff (srst)
		cpu_reset |-> (memory_request_n && io_request_n && read_strobe_n
		&& write_strobe_n && addr_oe_n && data_oe_n))
		else $error("controls active while reset pin seen low");

endmodule

/* test/bus_partner.sv */
// memory, port and interrupting device model facing the bus cycle sequencer
module bus_partner (
	input wire logic mclk, // system clock
	input wire logic srst, // synchronous reset
	input wire logic [15:0] addr_out, // address bus
	input wire logic [7:0] data_out, // write data
	input wire logic data_oe_n, // write data enable
	input wire logic memory_request_n, // memory request strobe
	input wire logic io_request_n, // I/O request strobe
	input wire logic read_strobe_n, // read strobe
	input wire logic write_strobe_n, // write strobe
	input wire logic fetch_cycle_n, // fetch-type cycle indicator
	input wire logic refresh_strobe_n, // refresh strobe
	input wire logic [1:0] stall_req, // extra wait states for the next transfer
	input wire logic [7:0] vector, // byte returned in interrupt acknowledge
	output logic [7:0] data_in, // data bus towards the sequencer
	output logic wait_n, // wait request
	output logic [15:0] wr_addr, // address of the last write
	output logic [7:0] wr_data // byte of the last write
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] last_reg;
	logic [2:0] stall_reg;
	logic busy_reg;
	logic start;

	// a transfer starts when memory request goes low outside refresh or I/O request goes low outside acknowledge
	assign start = (!memory_request_n && refresh_strobe_n) || (!io_request_n && fetch_cycle_n);
	assign wait_n = (stall_reg == 3'h0);
	// a released bus shows a changing pattern, never the last byte
	always_comb begin
		if (!read_strobe_n && !memory_request_n)
			data_in = addr_out[7:0] ^ addr_out[15:8] ^ 8'h5A;
		else if (!read_strobe_n && !io_request_n)
			data_in = ~addr_out[7:0];
		else if (!io_request_n && !fetch_cycle_n)
			data_in = vector;
		else
			data_in = ~last_reg;
	end
	// wait counter, last bus byte and write capture
	always_ff @(posedge mclk) begin
		last_reg <= data_in;
		busy_reg <= start;
		if (srst)
			stall_reg <= 3'h0;
		else if (start && !busy_reg)
			stall_reg <= {stall_req, 1'b0};
		else if (stall_reg != 3'h0)
			stall_reg <= stall_reg - 3'h1;
		if (!write_strobe_n && !data_oe_n) begin
			wr_addr <= addr_out;
			wr_data <= data_out;
		end
	end
endmodule

/* test/bus_cycle_sequencer_bench.sv */
// self-checking bench for the bus cycle sequencer
module bus_cycle_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, srst, ce, cmd_valid, cmd_ready, instr_last, done, int_pending, cpu_reset;
	logic addr_oe_n, data_oe_n, ctrl_oe_n, wait_n, int_n, bus_request_n, reset_n;
	logic memory_request_n, io_request_n, read_strobe_n, write_strobe_n;
	logic fetch_cycle_n, refresh_strobe_n, bus_grant_n;
	seq_pkg::kind_t cmd_kind;
	logic [15:0] cmd_addr, addr_out, wr_addr;
	logic [7:0] cmd_wdata, rdata, data_in, data_out, vector, wr_data;
	logic [1:0] stall_req;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;

	bus_cycle_sequencer u_dut (.mclk, .srst, .ce, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_addr,
		.cmd_wdata, .instr_last, .done, .rdata, .int_pending, .cpu_reset, .addr_out, .addr_oe_n,
		.data_in, .data_out, .data_oe_n, .memory_request_n, .io_request_n, .read_strobe_n,
		.write_strobe_n, .ctrl_oe_n, .fetch_cycle_n, .refresh_strobe_n, .bus_grant_n, .wait_n,
		.int_n, .bus_request_n, .reset_n);
	bus_partner u_partner (.mclk, .srst, .addr_out, .data_out, .data_oe_n, .memory_request_n,
		.io_request_n, .read_strobe_n, .write_strobe_n, .fetch_cycle_n, .refresh_strobe_n,
		.stall_req, .vector, .data_in, .wait_n, .wr_addr, .wr_data);

	// clock of 100 ns period
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// hang guard
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end

	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_val({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// memory contents as the partner holds them
	function automatic logic [7:0] mem_byte(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction
	// mclk cycles from take to the done pulse
	function automatic int cycle_len(input seq_pkg::kind_t k, input int w);
		case (k)
			seq_pkg::K_FETCH, seq_pkg::K_IO_RD, seq_pkg::K_IO_WR: return 8 + 2 * w;
			seq_pkg::K_INTACK: return 12 + 2 * w;
			default: return 6 + 2 * w;
		endcase
	endfunction

	// one machine cycle, watched at every falling edge
	task automatic run_cycle(input seq_pkg::kind_t k, input logic [15:0] a,
			input logic [7:0] wd, input int w);
		int n;
		int m1_at;
		int io_at;
		logic is_fetch;
		logic is_io;
		logic [7:0] exp;
		is_fetch = (k == seq_pkg::K_FETCH) || (k == seq_pkg::K_INTACK);
		is_io = (k == seq_pkg::K_IO_RD) || (k == seq_pkg::K_IO_WR);
		exp = (k == seq_pkg::K_IO_RD) ? ~a[7:0] : (k == seq_pkg::K_INTACK) ? vector : mem_byte(a);
		m1_at = -1;
		io_at = -1;
		stall_req = 2'(w);
		cmd_kind = k;
		cmd_addr = a;
		cmd_wdata = wd;
		cmd_valid = 1'b1;
		for (n = 0; n < 50 && cmd_ready !== 1'b1; n++)
			@(negedge mclk);
		@(negedge mclk);
		cmd_valid = 1'b0;
		cmp_val(addr_out, a);
		cmp_bit(addr_oe_n, 1'b0);
		cmp_bit(memory_request_n, 1'b1);
		for (n = 0; n < 60 && done !== 1'b1; n++) begin
			if (n == 1 && !is_io && k != seq_pkg::K_INTACK)
				cmp_bit(memory_request_n, 1'b0);
			if (!memory_request_n && refresh_strobe_n)
				cmp_val(addr_out, a);
			if (!io_request_n && is_io)
				cmp_val({addr_out[7:0], 7'h00, read_strobe_n & write_strobe_n}, {a[7:0], 8'h00});
			if (!write_strobe_n)
				cmp_val({8'h00, data_out}, {8'h00, wd});
			if (k == seq_pkg::K_INTACK && refresh_strobe_n)
				cmp_bit(memory_request_n, 1'b1);
			if (is_fetch && n == ((k == seq_pkg::K_INTACK) ? 8 : 4) + 2 * w)
				cmp_val({6'h00, refresh_strobe_n, addr_out[15:7]}, 16'h0000);
			if (!fetch_cycle_n && m1_at < 0)
				m1_at = n;
			if (!io_request_n && io_at < 0)
				io_at = n;
			@(negedge mclk);
		end
		cmp_val(16'(n), 16'(cycle_len(k, w)));
		if (k != seq_pkg::K_MEM_WR && k != seq_pkg::K_IO_WR)
			cmp_val({8'h00, rdata}, {8'h00, exp});
		else
			cmp_val({wr_addr[7:0], wr_data}, {a[7:0], wd});
		cmp_bit(m1_at >= 0, is_fetch);
		if (k == seq_pkg::K_INTACK)
			cmp_bit(io_at - m1_at >= 4, 1'b1);
	endtask

	initial begin
		int n;
		srst = 1'b1;
		ce = 1'b1;
		cmd_valid = 1'b0;
		cmd_kind = seq_pkg::K_FETCH;
		cmd_addr = 16'h0000;
		cmd_wdata = 8'h00;
		instr_last = 1'b0;
		int_n = 1'b1;
		bus_request_n = 1'b1;
		reset_n = 1'b1;
		stall_req = 2'h0;
		vector = 8'h00;
		void'($urandom(40254));
		repeat (10) @(negedge mclk);
		srst = 1'b0;
		cmp_val({12'h000, memory_request_n, io_request_n, addr_oe_n, ctrl_oe_n}, 16'h000E);
		// every kind with zero, one and two extra wait states, interrupt acknowledge with none
		for (int k = 0; k < 6; k++)
			for (int w = 0; w < 3; w++)
				run_cycle(seq_pkg::kind_t'(k), 16'($urandom), 8'($urandom), (k == 5) ? 0 : w);
		// interrupt seen only at the end of an instruction, then acknowledged
		int_n = 1'b0;
		run_cycle(seq_pkg::K_FETCH, 16'h1234, 8'h00, 0);
		cmp_bit(int_pending, 1'b0);
		instr_last = 1'b1;
		run_cycle(seq_pkg::K_MEM_RD, 16'hFFFF, 8'h00, 0);
		cmp_bit(int_pending, 1'b1);
		int_n = 1'b1;
		instr_last = 1'b0;
		vector = 8'($urandom);
		run_cycle(seq_pkg::K_INTACK, 16'h0000, 8'h00, 0);
		cmp_bit(int_pending, 1'b0);
		// bus handed over, then taken back
		bus_request_n = 1'b0;
		for (n = 0; n < 30 && bus_grant_n !== 1'b0; n++)
			@(negedge mclk);
		cmp_val({12'h000, bus_grant_n, addr_oe_n, data_oe_n, ctrl_oe_n}, 16'h0007);
		cmp_bit(cmd_ready, 1'b0);
		bus_request_n = 1'b1;
		for (n = 0; n < 30 && bus_grant_n !== 1'b1; n++)
			@(negedge mclk);
		cmp_bit(bus_grant_n, 1'b1);
		// reset pin floats the buses and idles the strobes; clock enable low freezes the sampling
		ce = 1'b0;
		reset_n = 1'b0;
		repeat (3) @(negedge mclk);
		cmp_val({14'h0000, cmd_ready, cpu_reset}, 16'h0000);
		ce = 1'b1;
		repeat (4) @(negedge mclk);
		cmp_val({12'h000, cpu_reset, memory_request_n, addr_oe_n, data_oe_n}, 16'h000F);
		reset_n = 1'b1;
		repeat (4) @(negedge mclk);
		// random traffic, back to back
		for (int i = 0; i < 40; i++) begin
			instr_last = 1'($urandom);
			run_cycle(seq_pkg::kind_t'(3'($urandom % 5)), 16'($urandom), 8'($urandom),
				int'($urandom % 3));
		end
		summarize();
	end
endmodule
